// ---- tb/tb_top.sv ----
// Purpose: scenario bench of the line front end
// Assumes: inputs change 1 ns after the rising edge
// Notes:   host bus used in both strobe styles
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       osc_in = 1'b0;
    logic       irq_req = 1'b0;
    logic       pulsed_mode = 1'b0;
    logic       rx_auto = 1'b0;
    logic       tx_valid = 1'b0;
    logic       tx_bit = 1'b1;
    logic       echo_en = 1'b1;
    logic       force_dom = 1'b0;
    logic       bad_a = 1'b0;
    logic [3:0] clk_div_code = 4'h0;
    logic [1:0] rx_manual_sel = 2'h0;
    logic [7:0] q;
    logic       ir;
    int         n;
    int         n2;
    int         err_count = 0;
    int         checks = 0;
    vblfe_pkg::vblfe_host_in_t hi = {1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
    wire [7:0]  ad_out;
    wire [1:0]  rx_active_sel;
    wire        ad_oe_b, int_out, int_oe_b, osc_out, buffered_clk_out, tx_ready, tx_out;
    wire        tx_oe_b, timeslot_clock, rx_slot_valid, rx_slot_level, arb_lost, in_reset;
    wire        line_in_a, line_in_b, line_in_c;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) osc_in <= #1 ~osc_in;
    vblfe_front_end i_vblfe_front_end (
        .core_clk, .rst_b, .osc_in, .osc_out, .buffered_clk_out, .host_in(hi), .ad_out,
        .ad_oe_b, .int_out, .int_oe_b, .irq_req, .clk_div_code, .pulsed_mode, .rx_auto,
        .rx_manual_sel, .tx_valid, .tx_bit, .tx_ready, .line_in_a, .line_in_b, .line_in_c,
        .tx_out, .tx_oe_b, .timeslot_clock, .rx_slot_valid, .rx_slot_level, .arb_lost,
        .rx_active_sel, .in_reset
    );
    vblfe_line_model i_vblfe_line_model (
        .tx_out, .tx_oe_b, .echo_en, .force_dom, .bad_a, .line_in_a, .line_in_b, .line_in_c
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int k = 1);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return timeslot_clock;
            1: return tx_ready;
            2: return rx_slot_valid;
            3: return arb_lost;
            4: return in_reset;
            default: return rx_active_sel != 2'h0;
        endcase
    endfunction
    task automatic wait_for(input int w, input logic lvl, input int lim, output int c);
        c = 0;
        while (sig(w) !== lvl && c < lim) begin
            tick();
            c++;
        end
        if (c >= lim) begin
            err_count++;
            summarize();
        end
    endtask
    // decoder raises the strobe only inside the processor strobe
    task automatic bus(input logic [2:0] m, input logic [7:0] a, input logic [7:0] d);
        hi.ale = 1'b1;
        hi.ad = a;
        tick();
        hi.ale = 1'b0;
        tick();
        {hi.cs, hi.rd, hi.wr} = m;
        hi.ad = d;
        tick(2);
        q = ad_out;
        ir = int_oe_b;
        {hi.cs, hi.rd, hi.wr} = 3'b011;
        hi.ad = ~d;
        tick();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        cmp("tx_out", 1'b1, tx_out);
        cmp("int_oe_b", 1'b1, int_oe_b);
        cmp("clk_out", 1'b0, buffered_clk_out);
        cmp("int_out", 1'b0, int_out);
        cmp("osc_out", !osc_in, osc_out);
        rst_b = 1'b1;
        wait_for(4, 1'b0, 40, n);
        cmp("settle", 9, n);
        cmp("clk_out", osc_in, buffered_clk_out);
    endtask
    task automatic t_host;
        bus(3'b101, 8'h20, 8'h5a);
        cmp("rd_unmapped", 8'h00, q);
        for (int k = 0; k < 2; k++) begin
            bus(k ? 3'b110 : 3'b100, vblfe_pkg::ADDR_CMD, 8'h01);
            wait_for(4, 1'b1, 6, n);
            wait_for(4, 1'b0, 20, n);
            bus(3'b101, vblfe_pkg::ADDR_CMD, 8'h00);
            cmp("cmd_read", 8'h00, q);
        end
    endtask
    task automatic t_irq;
        irq_req = 1'b1;
        tick();
        for (int a = 7; a <= 12; a++) begin
            bus(3'b101, 8'(a), 8'hff);
            cmp("int_release", a >= 8 && a <= 11, ir);
            tick();
            cmp("int_oe_b", 1'b0, int_oe_b);
        end
        irq_req = 1'b0;
    endtask
    task automatic t_div;
        // divisors rising, so no accumulator left over from a slower code
        for (int k = 0; k < 16; k++) begin
            int c;
            c = (k >> 1) + 8 * (k % 2);
            clk_div_code = 4'(c);
            wait_for(0, 1'b0, 5000, n);
            wait_for(0, 1'b1, 5000, n);
            wait_for(0, 1'b0, 5000, n);
            wait_for(0, 1'b1, 5000, n2);
            cmp("slot_period", c < 8 ? 16 << c : 24 << (c - 8), n + n2);
        end
        clk_div_code = 4'h0;
    endtask
    task automatic t_tx(input logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            tx_bit = b[i];
            tx_valid = 1'b1;
            wait_for(1, 1'b1, 40, n);
            tick(9);
            cmp("tx_nrz", b[i], tx_out);
        end
        tick(16);
        cmp("tx_split", !b[3], tx_out);
        tx_valid = 1'b0;
    endtask
    task automatic t_arb;
        force_dom = 1'b1;
        tx_bit = 1'b1;
        tx_valid = 1'b1;
        wait_for(1, 1'b1, 40, n);
        tick();
        tx_valid = 1'b0;
        wait_for(3, 1'b1, 40, n);
        cmp("arb_lost", 9, n);
        wait_for(2, 1'b1, 40, n);
        cmp("rx_level", 1'b0, rx_slot_level);
        force_dom = 1'b0;
    endtask
    // line stays recessive here, so a dominant slot can only come from loopback
    task automatic t_pulsed;
        // enter at a slot start so no sampled slot is cut short
        wait_for(1, 1'b1, 40, n);
        tick();
        pulsed_mode = 1'b1;
        echo_en = 1'b0;
        tick(20);
        tx_bit = 1'b0;
        tx_valid = 1'b1;
        wait_for(1, 1'b1, 40, n);
        tick();
        tx_valid = 1'b0;
        n = 0;
        n2 = 0;
        repeat (24) begin
            n += int'(tx_out === 1'b0);
            n2 |= int'(rx_slot_valid === 1'b1 && rx_slot_level === 1'b0);
            tick();
        end
        cmp("pulse_len", 2, n);
        cmp("loop_rx", 1, n2);
        pulsed_mode = 1'b0;
        echo_en = 1'b1;
    endtask
    task automatic t_sel;
        bad_a = 1'b1;
        rx_auto = 1'b1;
        wait_for(5, 1'b1, 200, n);
        cmp("auto_sel", 2'h1, rx_active_sel);
        rx_auto = 1'b0;
        rx_manual_sel = 2'h2;
        tick(40);
        cmp("manual_sel", 2'h2, rx_active_sel);
        bad_a = 1'b0;
    endtask
    initial begin
        tick(20);
        t_reset();
        tick(2);
        t_host();
        t_irq();
        t_div();
        t_tx(4'b0110);
        t_arb();
        t_pulsed();
        t_sel();
        summarize();
    end
endmodule // tb_top
`default_nettype wire

// ---- tb/vblfe_fe_props.sv ----
// Purpose: port checks of the line front end
// Assumes: one core clock, rst_b async low
// Notes:   code 0 gives one prescale tick per clock
`timescale 1ns/1ns
`default_nettype none
module vblfe_fe_props #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      rst_b,
    // host side
    input wire vblfe_pkg::vblfe_host_in_t host_in,
    input wire logic                      ad_oe_b,
    input wire logic                      int_oe_b,
    input wire logic                      irq_req,
    // clocks and line
    input wire logic                      osc_in,
    input wire logic                      buffered_clk_out,
    input wire logic [DIV_W-1:0]          clk_div_code,
    input wire logic                      pulsed_mode,
    input wire logic                      tx_out,
    input wire logic                      tx_oe_b,
    input wire logic                      timeslot_clock,
    input wire logic                      rx_slot_valid,
    input wire logic                      in_reset
);
    // ----------------------------------------
    // address latch mirror
    // ----------------------------------------
    logic [7:0] addr_reg;
    logic       acc;
    logic       rng;
    assign acc = host_in.cs & ~(host_in.rd & host_in.wr);
    assign rng = addr_reg >= vblfe_pkg::ADDR_IRQ_LO && addr_reg <= vblfe_pkg::ADDR_IRQ_HI;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            addr_reg <= 8'h00;
        else if (host_in.ale)
            addr_reg <= host_in.ad;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_int_release: assert property (acc && rng |-> int_oe_b)
        else $error("interrupt pin held during interrupt access");
    // accesses and the cycle after may release, so they are left out
    a_int_follow: assert property (irq_req && !in_reset && !acc && !$past(acc) |-> !int_oe_b)
        else $error("interrupt request not on pin");
    a_int_cause: assert property (!irq_req |-> int_oe_b)
        else $error("interrupt pin low without request");
    a_read_drive: assert property (ad_oe_b == !(host_in.cs && !host_in.rd && host_in.wr && !in_reset))
        else $error("data bus drive does not match read decode");
    a_clk_buf: assert property (buffered_clk_out == (osc_in && !in_reset))
        else $error("buffered clock wrong");
    a_reset_hold: assert property ($rose(rst_b) |-> in_reset[*8] ##1 in_reset ##1 !in_reset)
        else $error("reset settle length wrong");
    a_tx_park: assert property (tx_oe_b == in_reset)
        else $error("line driver enabled in reset");
    a_slot_half: assert property (disable iff (!rst_b || in_reset)
        $rose(timeslot_clock) && clk_div_code == '0 |->
        timeslot_clock[*8] ##1 (!timeslot_clock || clk_div_code != '0))
        else $error("timeslot half period not eight ticks");
    a_pulse_width: assert property (pulsed_mode && clk_div_code == '0 && $fell(tx_out) |->
        !tx_out ##1 !tx_out ##1 tx_out)
        else $error("pulsed dominant not two ticks");
    a_rx_spacing: assert property (rx_slot_valid && clk_div_code == '0 |=> !rx_slot_valid[*7])
        else $error("receive slots too close");
endmodule // vblfe_fe_props
bind vblfe_front_end vblfe_fe_props #(.DIV_W(DIV_W)) i_vblfe_fe_props (
    .core_clk, .rst_b, .host_in, .ad_oe_b, .int_oe_b, .irq_req, .osc_in,
    .buffered_clk_out, .clk_div_code, .pulsed_mode, .tx_out, .tx_oe_b,
    .timeslot_clock, .rx_slot_valid, .in_reset
);
`default_nettype wire

// ---- tb/vblfe_line_model.sv ----
// Purpose: line transceivers around the front end
// Assumes: wired-and line, high is recessive
// Notes:   optical mode hides own transmission
`timescale 1ns/1ns
`default_nettype none
module vblfe_line_model (
    // device pins
    input  wire logic tx_out,
    input  wire logic tx_oe_b,
    // scenario controls
    input  wire logic echo_en,
    input  wire logic force_dom,
    input  wire logic bad_a,
    // receive pins
    output logic      line_in_a,
    output logic      line_in_b,
    output logic      line_in_c
);
    // ----------------------------------------
    // wired-and line
    // ----------------------------------------
    logic lvl;
    // released driver leaves the pull-up, recessive
    assign lvl = !force_dom && (tx_oe_b || !echo_en || tx_out);
    assign line_in_a = lvl && !bad_a;
    assign line_in_b = lvl;
    assign line_in_c = lvl;
endmodule // vblfe_line_model
`default_nettype wire

// ---- verilog/vblfe_front_end.sv ----
// Purpose: host strobes, reset sequencing, prescaler and line interface
// Assumes: core_clk is the oscillator clock; pins synchronous to it
// Notes:   frame protocol and the main register map live outside
// Notes on behaviour
// RULE1 - strobe mode: write pin is read/write, read pin low, chip select is strobe
// RULE2 - external decoder raises the strobe only while the processor strobe is high
// RULE3 - access timed by command strobes, or by the enable strobe in strobe mode
// RULE4 - one active-low open-drain interrupt pin, sources set internally
// RULE5 - any access to 0x08..0x0B briefly releases the interrupt pin
// RULE6 - pin reset and soft reset bit at 0x03 combined into one reset
// RULE7 - internal reset asserts asynchronously, then waits eight clocks to settle; code holds in_reset for nine clocks after rst_b rises
// RULE8 - reset release is clocked; no clock keeps the device in reset
// RULE9 - buffered clock output follows the oscillator input, not inverted
// RULE10 - timeslot clock is oscillator divided by sixteen times n
// RULE11 - codes 0-7 give n 1..128, codes 8-15 give 1.5..192
// RULE12 - three line inputs, one output; input chosen by software or diagnosis
// RULE13 - diagnosis watches all inputs against each other and bit timing
// RULE14 - one recessive, zero dominant; own transmission is received back
// RULE15 - bitwise arbitration, collision leaves the winning message intact
// RULE16 - pulsed mode: dominant is low two prescaled clocks, recessive high
// RULE17 - pulsed mode decodes edges on first input only, no auto diagnosis
// RULE18 - pulsed mode loops transmit data back internally
// RULE19 - timeslot is sixteen prescaled clocks; pulsed mode replaces low slots
// RULE20 - buffered clock output driven only outside reset
// RULE21 - strobe high, read low, read/write low is a write; high is a read
// RULE22 - line data sent as three plain bits then one split-phase bit
// RULE23 - fault counts per input over a decaying window pick the best input
`timescale 1ns/1ns
`default_nettype none
module vblfe_front_end #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    // oscillator pins
    input  wire logic                     osc_in,
    output logic                          osc_out,
    output logic                          buffered_clk_out,
    // host bus
    input  wire vblfe_pkg::vblfe_host_in_t host_in,
    output logic [7:0]                    ad_out,
    output logic                          ad_oe_b,
    output logic                          int_out,
    output logic                          int_oe_b,
    // internal event and configuration
    input  wire logic                     irq_req,
    input  wire logic [DIV_W-1:0]         clk_div_code,
    input  wire logic                     pulsed_mode,
    input  wire logic                     rx_auto,
    input  wire logic [1:0]               rx_manual_sel,
    // transmit bit stream
    input  wire logic                     tx_valid,
    input  wire logic                     tx_bit,
    output logic                          tx_ready,
    // line pins
    input  wire logic                     line_in_a,
    input  wire logic                     line_in_b,
    input  wire logic                     line_in_c,
    output logic                          tx_out,
    output logic                          tx_oe_b,
    // receive and status
    output logic                          timeslot_clock,
    output logic                          rx_slot_valid,
    output logic                          rx_slot_level,
    output logic                          arb_lost,
    output logic [1:0]                    rx_active_sel,
    output logic                          in_reset
);
    // ------------------------------------------------------------
    // reset sequencing
    // ------------------------------------------------------------
    logic       soft_req_reg;
    logic [3:0] settle_reg;
    logic       hold_reg;
    logic       rst_core_b;

    // soft request restarts the same settle count as the pin
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_reg <= 4'h0; // RULE7
            hold_reg   <= 1'b1;
        end else if (soft_req_reg) begin
            settle_reg <= 4'h0; // RULE6
            hold_reg   <= 1'b1;
        end else if (settle_reg != 4'(vblfe_pkg::SETTLE_CYC)) begin
            settle_reg <= settle_reg + 4'h1; // RULE7
        end else begin
            hold_reg   <= 1'b0; // RULE8
        end
    end
    assign rst_core_b = rst_b & ~hold_reg; // RULE6
    assign in_reset   = hold_reg;

    // ------------------------------------------------------------
    // oscillator pins
    // ------------------------------------------------------------
    assign osc_out          = ~osc_in;
    assign buffered_clk_out = osc_in & ~hold_reg; // RULE9 RULE20

    // ------------------------------------------------------------
    // host bus
    // ------------------------------------------------------------
    logic [7:0] addr_reg;
    logic [7:0] cmd_reg;
    logic       acc_wr;
    logic       acc_rd;
    logic       wr_prev_reg;
    logic [7:0] wdata_reg;
    logic       irq_hit;
    logic       release_reg;

    // access decode straight from the pin table
    assign acc_rd = host_in.cs & ~host_in.rd & host_in.wr; // RULE1 RULE21
    assign acc_wr = host_in.cs & ~host_in.wr; // RULE1 RULE21

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            addr_reg <= 8'h00;
        end else if (host_in.ale) begin
            addr_reg <= host_in.ad;
        end
    end

    // write data held while the strobe is up, committed when it drops
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            wr_prev_reg <= 1'b0;
            wdata_reg   <= 8'h00;
        end else begin
            wr_prev_reg <= acc_wr;
            if (acc_wr) begin
                wdata_reg <= host_in.ad; // RULE3
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            cmd_reg      <= vblfe_pkg::CMD_RESET_VAL;
            soft_req_reg <= 1'b0;
        end else if (wr_prev_reg && !acc_wr && addr_reg == vblfe_pkg::ADDR_CMD) begin
            cmd_reg      <= wdata_reg; // RULE3
            soft_req_reg <= wdata_reg[vblfe_pkg::SOFT_RST_BIT]; // RULE6
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            ad_out <= 8'h00;
        end else if (addr_reg == vblfe_pkg::ADDR_CMD) begin
            ad_out <= cmd_reg & ~(8'h01 << vblfe_pkg::SOFT_RST_BIT);
        end else begin
            ad_out <= 8'h00;
        end
    end
    assign ad_oe_b = ~(acc_rd & ~hold_reg);

    // release lasts the access plus one clock so edge hosts see a rise
    assign irq_hit = (acc_rd | acc_wr) && addr_reg >= vblfe_pkg::ADDR_IRQ_LO
                     && addr_reg <= vblfe_pkg::ADDR_IRQ_HI;
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            release_reg <= 1'b0;
        end else begin
            release_reg <= irq_hit; // RULE5
        end
    end
    assign int_out  = 1'b0;
    assign int_oe_b = ~(irq_req & ~irq_hit & ~release_reg & ~hold_reg); // RULE4 RULE5

    // ------------------------------------------------------------
    // prescaler and timeslot
    // ------------------------------------------------------------
    function automatic logic [9:0] div_halves(input logic [DIV_W-1:0] code);
        logic [9:0] base;
        base = 10'h002 << code[2:0];
        return code[3] ? (base + (base >> 1)) : base; // RULE11
    endfunction

    logic [9:0] acc_reg;
    logic       presc_tick;
    logic [3:0] slot_reg;
    logic       slot_end;

    // half-clock accumulator keeps the 1.5 family on average rate
    assign presc_tick = (acc_reg + 10'h002) >= div_halves(clk_div_code);
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            acc_reg <= 10'h000;
        end else if (presc_tick) begin
            acc_reg <= acc_reg + 10'h002 - div_halves(clk_div_code); // RULE10
        end else begin
            acc_reg <= acc_reg + 10'h002;
        end
    end

    assign slot_end = presc_tick && slot_reg == 4'(vblfe_pkg::SLOT_TICKS - 1);
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            slot_reg <= 4'h0;
        end else if (presc_tick) begin
            slot_reg <= slot_reg + 4'h1; // RULE19 RULE10
        end
    end
    assign timeslot_clock = slot_reg[3];

    // ------------------------------------------------------------
    // transmit encoder
    // ------------------------------------------------------------
    vblfe_pkg::vblfe_enc_state_t enc_reg;
    logic [1:0] grp_reg;
    logic       bit_reg;
    logic       slot_lvl;

    assign tx_ready = slot_end && (enc_reg == vblfe_pkg::ENC_IDLE
                      || enc_reg == vblfe_pkg::ENC_NRZ || enc_reg == vblfe_pkg::ENC_MAN2);

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            enc_reg <= vblfe_pkg::ENC_IDLE;
            grp_reg <= 2'h0;
            bit_reg <= 1'b1;
        end else if (slot_end) begin
            unique case (enc_reg)
                vblfe_pkg::ENC_MAN1: begin
                    enc_reg <= vblfe_pkg::ENC_MAN2; // RULE22
                end
                default: begin
                    if (tx_valid) begin
                        bit_reg <= tx_bit;
                        grp_reg <= grp_reg + 2'h1;
                        enc_reg <= (grp_reg == 2'h3) ? vblfe_pkg::ENC_MAN1
                                                     : vblfe_pkg::ENC_NRZ; // RULE22
                    end else begin
                        enc_reg <= vblfe_pkg::ENC_IDLE;
                        grp_reg <= 2'h0;
                    end
                end
            endcase
        end
    end

    // split-phase bit sends its value then the complement
    always_comb begin
        slot_lvl = 1'b1;
        unique case (enc_reg)
            vblfe_pkg::ENC_IDLE: slot_lvl = 1'b1;
            vblfe_pkg::ENC_NRZ:  slot_lvl = bit_reg;
            vblfe_pkg::ENC_MAN1: slot_lvl = bit_reg;
            vblfe_pkg::ENC_MAN2: slot_lvl = ~bit_reg;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            tx_out <= 1'b1;
        end else if (pulsed_mode) begin
            tx_out <= slot_lvl | (slot_reg >= 4'(vblfe_pkg::PULSE_TICKS)); // RULE16 RULE19
        end else begin
            tx_out <= slot_lvl; // RULE14
        end
    end
    assign tx_oe_b = hold_reg;

    // ------------------------------------------------------------
    // input diagnosis
    // ------------------------------------------------------------
    logic [2:0] line_vec;
    logic [2:0] line_prev_reg;
    logic       majority;
    logic [7:0] decay_reg;
    logic [vblfe_pkg::FAULT_W-1:0] fault_reg [3];
    logic       edge_bad;

    assign line_vec = {line_in_c, line_in_b, line_in_a};
    assign majority = (line_vec[0] & line_vec[1]) | (line_vec[1] & line_vec[2])
                      | (line_vec[0] & line_vec[2]);
    assign edge_bad = slot_reg >= 4'(vblfe_pkg::EDGE_GUARD)
                      && slot_reg < 4'(vblfe_pkg::SLOT_TICKS - vblfe_pkg::EDGE_GUARD);

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            line_prev_reg <= 3'h7;
            decay_reg     <= 8'h00;
        end else begin
            line_prev_reg <= line_vec;
            if (slot_end) begin
                decay_reg <= decay_reg + 8'h01;
            end
        end
    end

    // window slides by halving every count once per decay period
    for (genvar i = 0; i < 3; i++) begin : g_diag
        always_ff @(posedge core_clk or negedge rst_core_b) begin
            if (!rst_core_b) begin
                fault_reg[i] <= '0;
            end else if (slot_end && decay_reg == 8'(vblfe_pkg::DECAY_SLOTS - 1)) begin
                fault_reg[i] <= fault_reg[i] >> 1; // RULE23
            end else if (fault_reg[i] != '1 && ((presc_tick && slot_reg ==
                         4'(vblfe_pkg::SAMPLE_TICK) && line_vec[i] != majority)
                         || (line_vec[i] != line_prev_reg[i] && edge_bad))) begin
                fault_reg[i] <= fault_reg[i] + 1'b1; // RULE13 RULE23
            end
        end
    end

    // in auto mode selection moves only at slot boundaries to avoid mid-slot glitches; manual and pulsed mode apply each clock
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            rx_active_sel <= 2'h0;
        end else if (pulsed_mode) begin
            rx_active_sel <= 2'h0; // RULE17
        end else if (!rx_auto) begin
            rx_active_sel <= rx_manual_sel; // RULE12
        end else if (slot_end) begin
            if (fault_reg[0] <= fault_reg[1] && fault_reg[0] <= fault_reg[2]) begin
                rx_active_sel <= 2'h0; // RULE13
            end else if (fault_reg[1] <= fault_reg[2]) begin
                rx_active_sel <= 2'h1;
            end else begin
                rx_active_sel <= 2'h2;
            end
        end
    end

    // ------------------------------------------------------------
    // receive and arbitration
    // ------------------------------------------------------------
    logic rx_pin;
    logic pulse_seen_reg;
    logic rx_level;

    assign rx_pin = (rx_active_sel == 2'h2) ? line_in_c
                  : (rx_active_sel == 2'h1) ? line_in_b : line_in_a; // RULE12

    // a falling edge anywhere in the slot marks it dominant
    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            pulse_seen_reg <= 1'b0;
        end else if (slot_end) begin
            pulse_seen_reg <= line_prev_reg[0] && !line_in_a; // RULE17
        end else if ((line_prev_reg[0] && !line_in_a) || !slot_lvl) begin
            pulse_seen_reg <= 1'b1; // RULE17 RULE18
        end
    end
    assign rx_level = pulsed_mode ? ~pulse_seen_reg : rx_pin;

    always_ff @(posedge core_clk or negedge rst_core_b) begin
        if (!rst_core_b) begin
            rx_slot_valid <= 1'b0;
            rx_slot_level <= 1'b1;
            arb_lost      <= 1'b0;
        end else begin
            rx_slot_valid <= 1'b0;
            arb_lost      <= 1'b0;
            if (pulsed_mode ? slot_end : (presc_tick &&
                slot_reg == 4'(vblfe_pkg::SAMPLE_TICK))) begin
                rx_slot_valid <= 1'b1; // RULE14
                rx_slot_level <= rx_level;
                arb_lost      <= slot_lvl & ~rx_level; // RULE15
            end
        end
    end
endmodule // vblfe_front_end
`default_nettype wire

// ---- verilog/vblfe_pkg.sv ----
// Purpose: shared constants and types of the vehicle bus line front end
// Assumes: one core clock of 20 MHz
// Notes:   offsets are host addresses on the multiplexed bus
package vblfe_pkg;
    // ------------------------------------------------------------
    // host map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD      = 8'h03;
    localparam logic [7:0] ADDR_IRQ_LO   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_HI   = 8'h0b;
    localparam int         SOFT_RST_BIT  = 0;
    localparam logic [7:0] CMD_RESET_VAL = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         CLK_MHZ       = 20;
    localparam int         SETTLE_CYC    = 8;
    localparam int         SLOT_TICKS    = 16;
    localparam int         PULSE_TICKS   = 2;
    localparam int         SAMPLE_TICK   = 8;
    localparam int         EDGE_GUARD    = 2;
    localparam int         DECAY_SLOTS   = 256;
    localparam int         FAULT_W       = 8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       ale;
        logic       rd;
        logic       wr;
        logic       cs;
        logic [7:0] ad;
    } vblfe_host_in_t;

    typedef enum logic [3:0] {
        ENC_IDLE = 4'b0001,
        ENC_NRZ  = 4'b0010,
        ENC_MAN1 = 4'b0100,
        ENC_MAN2 = 4'b1000
    } vblfe_enc_state_t;
endpackage
